// >>> hdl/sound_dac_playback.sv
/*
 sound playback controller with a classic wishbone register slave.
 assumes a single 50 MHz clock and an async active-low reset; the
 dma controller or cpu refills the sample word on request.
*/
// What this block does
// - dma request reaches the pin only while control bit 6 is set.
// - control bit 5 clear holds the block in power-down.
// - channel swap bit 3 clear sends the low byte left, set sends it right.
// - interrupt request reaches the pin only while control bit 0 is set.
// - stereo plays the low 16-bit half first, then the high half.
// - after the first slot (low half in stereo, lowest byte in mono) is consumed a new-word request is raised.
// - bit 7 selects mono; mono plays the lower byte before the higher.
// - mono presents the same sample on both dac outputs.
// - one new-data request per 32-bit word period, set by the rate.
// - rates of 44.1, 22.05, 11.025 and 8 kHz are supported.
`timescale 1ns/10ps
module sound_dac_playback (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [7:0] left_dac_out,
   output logic [7:0] right_dac_out,
   output logic dma_req,
   output logic irq_req,
   output logic irq
);

   logic rst_meta_q;
   logic rst_sync_q;
   sound_pkg::control_t control_q;
   logic [31:0] sample_q;
   logic word_full_q;
   logic [1:0] slot_q;
   logic [12:0] div_cnt_q;
   logic tick;
   logic need_word_q;
   logic [sound_pkg::num_events-1:0] status_q;
   logic [sound_pkg::num_events-1:0] enable_q;
   logic [sound_pkg::num_events-1:0] event_set;
   logic wr_stb;
   logic rd_stb;
   logic wr_control;
   logic wr_sample;
   logic wr_status;
   logic wr_enable;
   logic [sound_pkg::num_events-1:0] status_clr;
   logic first_slot_tick;
   logic last_slot_tick;
   logic [12:0] period;
   sound_pkg::dac_pair_t pair;
   logic [7:0] cur_byte;
   logic [15:0] cur_half;
   logic last_slot;

   function automatic logic [12:0] rate_period(input logic [1:0] sel);
      case (sel)
         2'h0: rate_period = sound_pkg::div_11k;
         2'h1: rate_period = sound_pkg::div_22k;
         2'h2: rate_period = sound_pkg::div_44k;
         default: rate_period = sound_pkg::div_8k;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // address decode shared by every register write; reads decode in read_word
   function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] off);
      reg_hit = (adr == off);
   endfunction

   // unmapped offsets read as zero rather than aliasing a register
   function automatic logic [31:0] read_word(input logic [3:0] adr,
                                             input sound_pkg::control_t ctl,
                                             input logic [31:0] smp,
                                             input logic [1:0] sts,
                                             input logic [1:0] ena);
      case (adr)
         sound_pkg::off_control: read_word = {24'h000000, ctl};
         sound_pkg::off_sample: read_word = smp;
         sound_pkg::off_irq_status: read_word = {30'h0, sts};
         sound_pkg::off_irq_enable: read_word = {30'h0, ena};
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   // async assert, release through two flops so no flop sees a runt edge

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ack drops the cycle after it is given, so requests never double-take
   assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   // control and status take byte lane 0 only; the word takes all four
   assign wr_control = wr_stb && reg_hit(wb_adr_i, sound_pkg::off_control) && wb_sel_i[0];
   assign wr_sample = wr_stb && reg_hit(wb_adr_i, sound_pkg::off_sample);
   assign wr_status = wr_stb && reg_hit(wb_adr_i, sound_pkg::off_irq_status) && wb_sel_i[0];
   assign wr_enable = wr_stb && reg_hit(wb_adr_i, sound_pkg::off_irq_enable) && wb_sel_i[0];

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_stb) begin
         wb_dat_o <= read_word(wb_adr_i, control_q, sample_q, status_q, enable_q);
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         control_q <= sound_pkg::control_reset;
      end else if (wr_control) begin
         control_q <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         enable_q <= '0;
      end else if (wr_enable) begin
         enable_q <= wb_dat_i[sound_pkg::num_events-1:0];
      end
   end

   // sample word; a write marks it full and withdraws the request
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         sample_q <= sound_pkg::sample_reset;
      end else if (wr_sample) begin
         sample_q <= merge(sample_q, wb_dat_i, wb_sel_i);
      end
   end

   // rate divider; stopped in power-down to save switching
   assign period = rate_period(control_q.rate_select);
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         div_cnt_q <= 13'h0000;
      end else if (!control_q.power_on) begin
         div_cnt_q <= 13'h0000;
      end else if (tick) begin
         div_cnt_q <= 13'h0000;
      end else begin
         div_cnt_q <= div_cnt_q + 13'h0001;
      end
   end
   assign tick = control_q.power_on && (div_cnt_q >= period - 13'h0001);

   // shared strobes for the first and last slot of a word
   assign first_slot_tick = tick && slot_q == 2'h0;
   assign last_slot_tick = tick && last_slot;

   // stereo: two samples per word, mono: four
   assign last_slot = control_q.mono ? (slot_q == 2'h3) : (slot_q == 2'h1);
   assign cur_half = slot_q[0] ? sample_q[31:16] : sample_q[15:0];
   always_comb begin
      cur_byte = sample_q[slot_q*8 +: 8];
      if (control_q.mono) begin
         pair.left = cur_byte;
         pair.right = cur_byte;
      end else if (control_q.channel_swap) begin
         pair.left = cur_half[15:8];
         pair.right = cur_half[7:0];
      end else begin
         pair.left = cur_half[7:0];
         pair.right = cur_half[15:8];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         slot_q <= 2'h0;
      end else if (!control_q.power_on) begin
         slot_q <= 2'h0;
      end else if (tick) begin
         slot_q <= last_slot ? 2'h0 : slot_q + 2'h1;
      end
   end

   // full flag only feeds underrun; playback itself never stalls
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         word_full_q <= 1'b0;
      end else if (wr_sample) begin
         word_full_q <= 1'b1;
      end else if (last_slot_tick) begin
         word_full_q <= 1'b0;
      end
   end

   // request after the first slot is played: once per word period
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         need_word_q <= 1'b0;
      end else if (!control_q.power_on) begin
         need_word_q <= 1'b0;
      end else if (wr_sample) begin
         need_word_q <= 1'b0;
      end else if (first_slot_tick) begin
         need_word_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         dma_req <= 1'b0;
      end else begin
         dma_req <= need_word_q && control_q.dma_unmask;
      end
   end

   // interrupt path masked on its own; software keeps only one unmasked
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= need_word_q && control_q.irq_unmask;
      end
   end

   // dac holds its last value while disabled, no idle toggling
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         left_dac_out <= 8'h00;
         right_dac_out <= 8'h00;
      end else if (!control_q.power_on) begin
         left_dac_out <= 8'h00;
         right_dac_out <= 8'h00;
      end else if (control_q.dac_enable && tick) begin
         left_dac_out <= pair.left;
         right_dac_out <= pair.right;
      end
   end

   // sticky status; a set in the clear cycle wins
   always_comb begin
      event_set = '0;
      event_set[sound_pkg::evt_word_taken] = first_slot_tick;
      event_set[sound_pkg::evt_underrun] = last_slot_tick && !word_full_q;
   end

   // write-one-to-clear mask, zero outside a status write
   always_comb begin
      status_clr = '0;
      if (wr_status) begin
         status_clr = wb_dat_i[sound_pkg::num_events-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~status_clr) | event_set;
      end
   end

   // registered so the pin never glitches on a status write
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & enable_q);
      end
   end

endmodule

// >>> hdl/sound_pkg.sv
/*
 sound playback controller package: register offsets, control fields,
 reset values, rate divider counts and carrier structs.
 assumes a 50 MHz system clock.
*/
package sound_pkg;

   localparam logic [3:0] off_control = 4'h0;
   localparam logic [3:0] off_sample = 4'h4;
   localparam logic [3:0] off_irq_status = 4'h8;
   localparam logic [3:0] off_irq_enable = 4'hc;

   localparam int bit_irq_mask = 0;
   localparam int bit_rate_lo = 1;
   localparam int bit_channel_swap = 3;
   localparam int bit_dac_enable = 4;
   localparam int bit_power = 5;
   localparam int bit_dma_mask = 6;
   localparam int bit_mono = 7;

   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [31:0] sample_reset = 32'h0000_0000;

   localparam int evt_word_taken = 0;
   localparam int evt_underrun = 1;
   localparam int num_events = 2;

   localparam int clk_hz = 50_000_000;
   localparam int rate_hz_44k = 44_100;
   localparam int rate_hz_22k = 22_050;
   localparam int rate_hz_11k = 11_025;
   localparam int rate_hz_8k = 8_000;
   localparam logic [12:0] div_44k = 13'(clk_hz / rate_hz_44k);
   localparam logic [12:0] div_22k = 13'(clk_hz / rate_hz_22k);
   localparam logic [12:0] div_11k = 13'(clk_hz / rate_hz_11k);
   localparam logic [12:0] div_8k = 13'(clk_hz / rate_hz_8k);

   typedef struct packed {
      logic mono;
      logic dma_unmask;
      logic power_on;
      logic dac_enable;
      logic channel_swap;
      logic [1:0] rate_select;
      logic irq_unmask;
   } control_t;

   typedef struct packed {
      logic [7:0] left;
      logic [7:0] right;
   } dac_pair_t;

endpackage

// >>> test/sound_dac_playback_checker.sv
/* port checker for sound_dac_playback.
 assumes it is bound to the block and that sel is full on control writes. */
`timescale 1ns/10ps
module sound_dac_playback_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [7:0] left_dac_out,
   input wire logic [7:0] right_dac_out,
   input wire logic dma_req,
   input wire logic irq_req
);
   logic [7:0] c_q;
   // shadow of control, taken while ack is high, one edge after the block takes the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c_q <= 8'h00;
      end else if (wb_ack_o && wb_we_i && wb_adr_i == sound_pkg::off_control) begin
         c_q <= wb_dat_i[7:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_off; !c_q[5] [*3]; endsequence
   sequence s_hold; (c_q[5] && !c_q[4]) [*2]; endsequence
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_DMA_MASK: assert property (!c_q[6] && !$past(c_q[6]) |-> !dma_req)
      else $error("dma request while masked");
   AST_IRQ_MASK: assert property (!c_q[0] && !$past(c_q[0]) |-> !irq_req)
      else $error("irq request while masked");
   AST_POWER: assert property (s_off |-> left_dac_out == 8'h00 && right_dac_out == 8'h00)
      else $error("dac active in power-down");
   AST_DAC_HOLD: assert property (s_hold |-> $stable({left_dac_out, right_dac_out}))
      else $error("dac moved while disabled");
   AST_MONO: assert property (c_q[7] && $past(c_q[7]) && $changed(left_dac_out)
      |-> left_dac_out == right_dac_out) else $error("mono channels differ");
   AST_REQ_CLEAR: assert property (wb_ack_o && wb_we_i && wb_adr_i == sound_pkg::off_sample
      |-> ##[1:2] !dma_req && !irq_req) else $error("request not withdrawn");
endmodule
bind sound_dac_playback sound_dac_playback_checker i_chk (.*);

// >>> test/sound_host_model.sv
/* dma or cpu stand-in: raises refill a set delay after a request.
 assumes one clock; a slow delay shows late refills. */
`timescale 1ns/10ps
module sound_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dma_req,
   input wire logic irq_req,
   input wire logic [7:0] delay,
   output logic refill
);
   logic [7:0] n_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n_q <= 8'h00;
      end else if (!(dma_req || irq_req)) begin
         n_q <= 8'h00;
      end else if (n_q <= delay) begin
         n_q <= n_q + 8'h01;
      end
   end
   // one refill per request, never before one is seen
   assign refill = (dma_req || irq_req) && n_q == delay;
endmodule

// >>> test/test_sound_dac_playback.sv
/* bench for sound_dac_playback: registers, modes, rates, requests, interrupt.
 assumes sound_pkg and sound_host_model. */
`timescale 1ns/10ps
module test_sound_dac_playback;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rd;
   logic ack, dma, irq_r, irq, refill;
   logic [7:0] lo, ro;
   logic [7:0] dly = 8'h00;
   int error_cnt = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   sound_dac_playback i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd),
      .wb_ack_o(ack), .left_dac_out(lo), .right_dac_out(ro), .dma_req(dma),
      .irq_req(irq_r), .irq(irq));
   sound_host_model i_host (.clk(clk), .rst_n(rst_n), .dma_req(dma), .irq_req(irq_r),
      .delay(dly), .refill(refill));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // idle edge after ack keeps cycles apart
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         error_cnt++;
      end
      cyc <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_out(output int n);
      logic [15:0] old;
      old = {lo, ro};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ({lo, ro} === old && n < 7000);
      if ({lo, ro} === old) begin
         error_cnt++;
      end
   endtask
   task automatic reset_dut();
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_regs();
      bus(0, sound_pkg::off_control, 32'h0);
      chk(rd, 32'(sound_pkg::control_reset));
      bus(1, sound_pkg::off_control, 32'h20);
      repeat (20) @(posedge clk);
      bus(0, sound_pkg::off_control, 32'h0);
      chk(rd, 32'h20);
      bus(1, sound_pkg::off_sample, 32'ha5c3_0f96);
      bus(0, sound_pkg::off_sample, 32'h0);
      chk(rd, 32'ha5c3_0f96);
      bus(1, sound_pkg::off_irq_enable, 32'h3);
      bus(0, sound_pkg::off_irq_enable, 32'h0);
      chk(rd, 32'h3);
      bus(1, 4'h2, 32'hffff_ffff);
      bus(0, 4'h2, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_play(input logic [7:0] c, input logic [15:0] s0, input logic [15:0] s1,
      input int per);
      int n;
      reset_dut();
      dly <= c[6] ? 8'h40 : 8'h00;
      bus(1, sound_pkg::off_irq_enable, 32'(c[0]));
      bus(1, sound_pkg::off_control, 32'(c));
      bus(1, sound_pkg::off_sample, 32'h4433_2211);
      n = 0;
      while (refill !== 1'b1 && n < 7000) begin
         @(posedge clk);
         n++;
      end
      if (refill !== 1'b1) begin
         error_cnt++;
      end
      chk(32'({dma, irq_r, irq}), 32'({c[6], c[0], c[0]}));
      chk(32'({lo, ro}), 32'(s0));
      bus(0, sound_pkg::off_irq_status, 32'h0);
      chk(rd, 32'h1);
      bus(1, sound_pkg::off_irq_status, 32'h1);
      @(posedge clk);
      chk(32'(irq), 32'h0);
      bus(1, sound_pkg::off_sample, 32'h4433_2211);
      wait_out(n);
      chk(32'({lo, ro}), 32'(s1));
      wait_out(n);
      chk(n, per);
   endtask
   initial begin
      reset_dut();
      t_regs();
      t_play(8'h74, 16'h1122, 16'h3344, sound_pkg::div_44k);
      t_play(8'h3b, 16'h2211, 16'h4433, sound_pkg::div_22k);
      t_play(8'hb1, 16'h1111, 16'h2222, sound_pkg::div_11k);
      t_play(8'hfe, 16'h1111, 16'h2222, sound_pkg::div_8k);
      conclude();
   end
   initial begin
      #2_000_000;
      error_cnt++;
      conclude();
   end
endmodule
